// ### cct_map.svh
// cct_map.svh: field positions, reset values and counts of the capture/compare timer
// assumes: included by the timer modules, not by cct_pkg.sv; holds definitions only
`ifndef CCT_MAP_SVH
`define CCT_MAP_SVH

// ----------------------------------------------------------------
// control register a fields
// ----------------------------------------------------------------
`define CCT_CRA_EN        7
`define CCT_CRA_TS        6
`define CCT_CRA_CR        2
`define CCT_CRA_SCE       1
`define CCT_CRA_AC        0
`define CCT_CRA_RST       8'h00

// ----------------------------------------------------------------
// action mask register fields
// ----------------------------------------------------------------
`define CCT_CRB_CPRM      6
`define CCT_CRB_CRMB      5
`define CCT_CRB_SAMB      4
`define CCT_CRB_CTMB      3
`define CCT_CRB_CRMA      2
`define CCT_CRB_SAMA      1
`define CCT_CRB_CTMA      0
`define CCT_CRB_RST       8'h00

// ----------------------------------------------------------------
// mode register a fields
// ----------------------------------------------------------------
`define CCT_MRA_ICS_HI    7
`define CCT_MRA_ICS_LO    6
`define CCT_MRA_CNC       5
`define CCT_MRA_CE_HI     4
`define CCT_MRA_CE_LO     3
`define CCT_MRA_CS_HI     2
`define CCT_MRA_CS_LO     0
`define CCT_MRA_RST       8'h00

// ----------------------------------------------------------------
// mode register b, flag and mask layout
// ----------------------------------------------------------------
`define CCT_MRB_MODE_HI   3
`define CCT_MRB_MODE_LO   0
`define CCT_MRB_TOP       4
`define CCT_MRB_RST       8'h00
`define CCT_IRQ_OVF       0
`define CCT_IRQ_CMA       1
`define CCT_IRQ_CMB       2
`define CCT_IRQ_CAP       3
`define CCT_IRQ_RST       4'h0

// ----------------------------------------------------------------
// counts
// ----------------------------------------------------------------
`define CCT_FILT_SAMPLES  4
`define CCT_CNT_MAX       16'hffff
`define CCT_CNT_RST       16'h0000

`endif

// ### cct_pkg.sv
// cct_pkg.sv: types of the capture/compare timer
// assumes: compiled before the timer modules

package cct_pkg;
   typedef enum logic [2:0] {
      CCT_CS_IO    = 3'b000,
      CCT_CS_EXTA  = 3'b001,
      CCT_CS_EXTB  = 3'b010,
      CCT_CS_T0    = 3'b011,
      CCT_CS_T1    = 3'b100,
      CCT_CS_T2    = 3'b101,
      CCT_CS_SENS  = 3'b110,
      CCT_CS_BASE  = 3'b111
   } cct_clk_sel_t;

   typedef enum logic [1:0] {
      CCT_CAP_PIN  = 2'b00,
      CCT_CAP_LF   = 2'b01,
      CCT_CAP_T1   = 2'b10,
      CCT_CAP_T2   = 2'b11
   } cct_cap_src_t;

   typedef enum logic [1:0] {
      CCT_EDGE_OFF  = 2'b00,
      CCT_EDGE_RISE = 2'b01,
      CCT_EDGE_FALL = 2'b10,
      CCT_EDGE_BOTH = 2'b11
   } cct_edge_t;

   typedef enum logic [3:0] {
      CCT_MODE_TIMER  = 4'b0000,
      CCT_MODE_TOGGLE = 4'b0001,
      CCT_MODE_PWM    = 4'b0010,
      CCT_MODE_SENSOR = 4'b0011
   } cct_mode_t;

   typedef enum logic [1:0] {
      CCT_SM_IDLE  = 2'b00,
      CCT_SM_ARMED = 2'b01,
      CCT_SM_RUN   = 2'b10
   } cct_sens_state_t;
endpackage

// ### cct_cap_filter.sv
// cct_cap_filter.sv: capture input filter and edge detector
// assumes: in_sig is already synchronised to clk_sys; tick marks one count clock cycle
`timescale 1ns/1ps
`include "cct_map.svh"

module cct_cap_filter
   import cct_pkg::*;
(
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       sys_rst,
   // control
   input  wire logic       tick,
   input  wire logic       filt_en,
   input  wire cct_edge_t  edge_sel,
   // signal
   input  wire logic       in_sig,
   output logic            edge_hit
);
   logic [`CCT_FILT_SAMPLES-1:0] hist;
   logic                         filt;
   logic                         prev;
   logic                         level;
   logic                         all_one;
   logic                         all_zero;
   logic                         next_filt;

   // ------------------------------------------------------------
   // filter
   // ------------------------------------------------------------
   // four equal samples
   assign all_one   = &hist;
   assign all_zero  = ~|hist;
   assign next_filt = all_one ? 1'b1 : (all_zero ? 1'b0 : filt);
   assign level     = filt_en ? filt : in_sig;

   // sample history on count clock ticks
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         hist <= '0;
         filt <= 1'b0;
      end else if (tick) begin
         hist <= {hist[`CCT_FILT_SAMPLES-2:0], in_sig};
         filt <= next_filt;
      end
   end

   // ------------------------------------------------------------
   // edge detect
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         prev <= 1'b0;
      end else begin
         prev <= level;
      end
   end

   assign edge_hit = ((edge_sel == CCT_EDGE_RISE) && level && !prev) ||
                     ((edge_sel == CCT_EDGE_FALL) && !level && prev) ||
                     ((edge_sel == CCT_EDGE_BOTH) && (level != prev));
endmodule

// ### cct_timer16.sv
// cct_timer16.sv: 16-bit capture/compare timer with modulator output
// assumes: register values come in as ports from a cpu-side register block;
// external clocks and triggers are asynchronous levels sampled on clk_sys
`timescale 1ns/1ps
`include "cct_map.svh"

module cct_timer16
   import cct_pkg::*;
(
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   // control registers
   input  wire logic [7:0]  ctrl_reg_a,
   input  wire logic [7:0]  action_mask_reg,
   input  wire logic [7:0]  mode_reg_a,
   input  wire logic [7:0]  mode_reg_b,
   input  wire logic [3:0]  irq_mask_reg,
   input  wire logic [15:0] compare_a_reg,
   input  wire logic [15:0] compare_b_reg,
   // software strobes
   input  wire logic        sw_capture_req,
   input  wire logic [3:0]  irq_flag_clr,
   // count clock sources
   input  wire logic        io_clock,
   input  wire logic        ext_clock_in_a,
   input  wire logic        ext_clock_in_b,
   input  wire logic        timer0_out_clock,
   input  wire logic        timer1_out_clock,
   input  wire logic        timer2_out_clock,
   input  wire logic        sensor_osc_clock,
   input  wire logic        timer_base_clock,
   // capture sources and companion timer
   input  wire logic        ext_capture_pin,
   input  wire logic        lf_rx_data_out,
   input  wire logic        companion_match,
   input  wire logic        sensor_meas_start,
   // status
   output logic [15:0]      count_value,
   output logic [15:0]      capture_value_reg,
   output logic [3:0]       irq_flag_reg,
   output logic             sw_capture_busy,
   output logic             capture_irq,
   output logic             match_a_irq,
   output logic             match_b_irq,
   output logic             overflow_irq,
   output logic             count_clock,
   output logic             modulator_out_pin,
   output logic             sensor_running
);
   // synchroniser stages for asynchronous inputs
   logic [7:0]       clk_s1;
   logic [7:0]       clk_s2;
   logic [3:0]       cap_s1;
   logic [3:0]       cap_s2;
   logic             tick_prev;
   logic             tick;
   logic             cnt_clk_lvl;
   logic             cap_lvl;
   logic             cap_edge;
   logic             cap_event;
   logic [15:0]      cnt;
   logic [15:0]      next_cnt;
   logic             sce_pend;
   logic             alt_sel_b;
   logic             sa_done_a;
   logic             sa_done_b;
   logic             en_prev;
   logic             mod_ff;
   logic [3:0]       flags;
   logic             hit_a;
   logic             hit_b;
   logic             match_a;
   logic             match_b;
   logic             ovf;
   logic             clr_cnt;
   logic             tgl;
   logic             enabled;
   logic             start;
   logic             alt_en;
   logic [3:0]       set_flags;
   cct_clk_sel_t     clk_sel;
   cct_cap_src_t     cap_src;
   cct_edge_t        edge_sel;
   cct_mode_t        mode;
   cct_sens_state_t  sm_state;
   cct_sens_state_t  next_sm_state;

   // ------------------------------------------------------------
   // field decode
   // ------------------------------------------------------------
   assign clk_sel  = cct_clk_sel_t'(mode_reg_a[`CCT_MRA_CS_HI:`CCT_MRA_CS_LO]);
   assign cap_src  = cct_cap_src_t'(mode_reg_a[`CCT_MRA_ICS_HI:`CCT_MRA_ICS_LO]);
   assign edge_sel = cct_edge_t'(mode_reg_a[`CCT_MRA_CE_HI:`CCT_MRA_CE_LO]);
   assign mode     = cct_mode_t'(mode_reg_b[`CCT_MRB_MODE_HI:`CCT_MRB_MODE_LO]);
   assign alt_en   = ctrl_reg_a[`CCT_CRA_AC];

   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         clk_s1 <= 8'h00;
         clk_s2 <= 8'h00;
         cap_s1 <= 4'h0;
         cap_s2 <= 4'h0;
      end else begin
         clk_s1 <= {timer_base_clock, sensor_osc_clock, timer2_out_clock, timer1_out_clock,
                    timer0_out_clock, ext_clock_in_b, ext_clock_in_a, io_clock};
         clk_s2 <= clk_s1;
         cap_s1 <= {timer2_out_clock, timer1_out_clock, lf_rx_data_out, ext_capture_pin};
         cap_s2 <= cap_s1;
      end
   end

   assign cnt_clk_lvl = clk_s2[clk_sel];
   assign cap_lvl     = cap_s2[cap_src];

   // count clock rising edge gives one tick
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         tick_prev <= 1'b0;
      end else begin
         tick_prev <= cnt_clk_lvl;
      end
   end
   assign tick        = cnt_clk_lvl && !tick_prev;
   assign count_clock = tick_prev;

   // ------------------------------------------------------------
   // capture input path
   // ------------------------------------------------------------
   // filter and edge detect
   cct_cap_filter u_filter (
      .clk_sys  (clk_sys),
      .sys_rst  (sys_rst),
      .tick     (tick),
      .filt_en  (mode_reg_a[`CCT_MRA_CNC]),
      .edge_sel (edge_sel),
      .in_sig   (cap_lvl),
      .edge_hit (cap_edge)
   );

   // companion match captures in sensor mode
   assign cap_event = (mode == CCT_MODE_SENSOR) ? (companion_match && sm_state == CCT_SM_RUN)
                                                 : (cap_edge || sce_pend);

   // ------------------------------------------------------------
   // compare and action decode
   // ------------------------------------------------------------
   assign enabled = ctrl_reg_a[`CCT_CRA_EN] &&
                    ((mode != CCT_MODE_SENSOR) || (sm_state == CCT_SM_RUN));
   assign start   = enabled && !en_prev;
   assign hit_a   = enabled && tick && (cnt == compare_a_reg);
   assign hit_b   = enabled && tick && (cnt == compare_b_reg);
   // alternate A then B; both live when off
   // single action fires once per start
   assign match_a = hit_a && !(alt_en && alt_sel_b) &&
                    !(action_mask_reg[`CCT_CRB_SAMA] && sa_done_a);
   assign match_b = hit_b && !(alt_en && !alt_sel_b) &&
                    !(action_mask_reg[`CCT_CRB_SAMB] && sa_done_b);
   assign clr_cnt = ctrl_reg_a[`CCT_CRA_CR] ||
                    (match_a && action_mask_reg[`CCT_CRB_CRMA]) ||
                    (match_b && action_mask_reg[`CCT_CRB_CRMB]) ||
                    (cap_event && action_mask_reg[`CCT_CRB_CPRM]);
   assign ovf     = enabled && tick && (cnt == `CCT_CNT_MAX) && !clr_cnt;
   assign tgl     = (match_a && action_mask_reg[`CCT_CRB_CTMA]) ||
                    (match_b && action_mask_reg[`CCT_CRB_CTMB]) ||
                    (start && ctrl_reg_a[`CCT_CRA_TS]);
   // up count; single action holds after reaching compare
   assign next_cnt = clr_cnt ? `CCT_CNT_RST :
                     ((enabled && tick && !((action_mask_reg[`CCT_CRB_SAMA] && (sa_done_a || match_a)) ||
                                            (action_mask_reg[`CCT_CRB_SAMB] && (sa_done_b || match_b))))
                      ? cnt + 16'h0001 : cnt);

   // ------------------------------------------------------------
   // counter, capture, single action and alternation state
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         cnt               <= `CCT_CNT_RST;
         capture_value_reg <= `CCT_CNT_RST;
      end else begin
         cnt <= next_cnt;
         if (cap_event) begin
            capture_value_reg <= cnt;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         sa_done_a <= 1'b0;
         sa_done_b <= 1'b0;
         alt_sel_b <= 1'b0;
         en_prev   <= 1'b0;
      end else begin
         en_prev <= enabled;
         if (start || !enabled) begin
            sa_done_a <= 1'b0;
            sa_done_b <= 1'b0;
            alt_sel_b <= 1'b0;
         end else begin
            sa_done_a <= sa_done_a | match_a;
            sa_done_b <= sa_done_b | match_b;
            if (match_a || match_b) begin
               alt_sel_b <= !alt_sel_b;
            end
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         sce_pend <= 1'b0;
      end else if (sw_capture_req) begin
         sce_pend <= 1'b1;
      end else if (cap_event) begin
         sce_pend <= 1'b0;
      end
   end
   assign sw_capture_busy = sce_pend;

   // ------------------------------------------------------------
   // modulator output
   // ------------------------------------------------------------
   // toggle flip-flop, preset while disabled
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         mod_ff <= 1'b0;
      end else if (!ctrl_reg_a[`CCT_CRA_EN]) begin
         mod_ff <= mode_reg_b[`CCT_MRB_TOP];
      end else if (tgl) begin
         mod_ff <= !mod_ff;
      end
   end
   assign modulator_out_pin = (mode == CCT_MODE_TIMER) ? 1'b0 : mod_ff;

   // ------------------------------------------------------------
   // sensor start synchroniser
   // ------------------------------------------------------------
   // start aligned to count tick
   always_comb begin
      next_sm_state = sm_state;
      case (sm_state)
         CCT_SM_IDLE: begin
            if (mode == CCT_MODE_SENSOR && sensor_meas_start) begin
               next_sm_state = CCT_SM_ARMED;
            end
         end
         CCT_SM_ARMED: begin
            if (!sensor_meas_start) begin
               next_sm_state = CCT_SM_IDLE;
            end else if (tick) begin
               next_sm_state = CCT_SM_RUN;
            end
         end
         CCT_SM_RUN: begin
            if (!sensor_meas_start || mode != CCT_MODE_SENSOR) begin
               next_sm_state = CCT_SM_IDLE;
            end
         end
         default: begin
            next_sm_state = CCT_SM_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         sm_state <= CCT_SM_IDLE;
      end else begin
         sm_state <= next_sm_state;
      end
   end
   assign sensor_running = (sm_state == CCT_SM_RUN);

   // ------------------------------------------------------------
   // flags and masked requests
   // ------------------------------------------------------------
   // sticky flags, set wins over clear
   assign set_flags = {cap_event, match_b, match_a, ovf};
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         flags <= `CCT_IRQ_RST;
      end else begin
         flags <= (flags & ~irq_flag_clr) | set_flags;
      end
   end
   assign irq_flag_reg = flags;
   assign count_value  = cnt;
   assign overflow_irq = flags[`CCT_IRQ_OVF] & irq_mask_reg[`CCT_IRQ_OVF];
   assign match_a_irq  = flags[`CCT_IRQ_CMA] & irq_mask_reg[`CCT_IRQ_CMA];
   assign match_b_irq  = flags[`CCT_IRQ_CMB] & irq_mask_reg[`CCT_IRQ_CMB];
   assign capture_irq  = flags[`CCT_IRQ_CAP] & irq_mask_reg[`CCT_IRQ_CAP];
endmodule

// ### cct_timer16_monitor.sv
// cct_timer16_monitor.sv: port checks of the capture/compare timer
// assumes: bound to cct_timer16; a single clock domain
`timescale 1ns/1ps

module cct_timer16_monitor
   import cct_pkg::*;
(
   // clock and reset
   input wire logic        clk_sys,
   input wire logic        sys_rst,
   // controls
   input wire logic [7:0]  mode_reg_b,
   input wire logic [3:0]  irq_mask_reg,
   input wire logic        sw_capture_req,
   input wire logic [3:0]  irq_flag_clr,
   // status
   input wire logic [15:0] count_value,
   input wire logic [15:0] capture_value_reg,
   input wire logic [3:0]  irq_flag_reg,
   input wire logic        sw_capture_busy,
   input wire logic        capture_irq,
   input wire logic        match_a_irq,
   input wire logic        match_b_irq,
   input wire logic        overflow_irq,
   input wire logic        modulator_out_pin
);
   // -------------
   // clocking
   // -------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   // software capture answered, then flagged
   sequence swcap_taken;
      ##[1:8] !sw_capture_busy ##[0:2] irq_flag_reg[3];
   endsequence

   // request lines are flag and mask
   irq_ovf_a: assert property (overflow_irq == (irq_flag_reg[0] & irq_mask_reg[0]))
      else $error("overflow irq wrong");
   irq_cma_a: assert property (match_a_irq == (irq_flag_reg[1] & irq_mask_reg[1]))
      else $error("match a irq wrong");
   irq_cmb_a: assert property (match_b_irq == (irq_flag_reg[2] & irq_mask_reg[2]))
      else $error("match b irq wrong");
   irq_cap_a: assert property (capture_irq == (irq_flag_reg[3] & irq_mask_reg[3]))
      else $error("capture irq wrong");
   // flags drop only when cleared
   flag_sticky_a: assert property (($past(irq_flag_reg) & ~irq_flag_reg & ~$past(irq_flag_clr)) == 4'h0)
      else $error("flag lost");
   // counter steps up by one or clears
   count_step_a: assert property (!$stable(count_value) |->
      (count_value == 16'h0000) || (count_value == $past(count_value) + 16'h0001))
      else $error("count jump");
   // capture register loads only with a capture
   cap_hold_a: assert property (!$stable(capture_value_reg) |-> ##[0:1] irq_flag_reg[3])
      else $error("capture without flag");
   swcap_done_a: assert property ($rose(sw_capture_req) && mode_reg_b[3:0] != 4'h3 |-> swcap_taken)
      else $error("sw capture not taken");
   mod_idle_a: assert property (mode_reg_b[3:0] == 4'h0 && $past(mode_reg_b[3:0]) == 4'h0
      |-> !modulator_out_pin)
      else $error("output moves in mode 0");
endmodule

bind cct_timer16 cct_timer16_monitor u_mon (
   .clk_sys, .sys_rst, .mode_reg_b, .irq_mask_reg, .sw_capture_req, .irq_flag_clr, .count_value,
   .capture_value_reg, .irq_flag_reg, .sw_capture_busy, .capture_irq, .match_a_irq, .match_b_irq,
   .overflow_irq, .modulator_out_pin
);

// ### cct_clk_partner.sv
// cct_clk_partner.sv: count clock sources seen by the timer
// assumes: a burst of len rising edges on source sel, low between bursts
`timescale 1ns/1ps

module cct_clk_partner
   import cct_pkg::*;
(
   // clock and reset
   input  wire logic         clk_sys,
   input  wire logic         sys_rst,
   // burst request
   input  wire logic         go,
   input  wire cct_clk_sel_t sel,
   input  wire logic [7:0]   len,
   // sources and status
   output logic [7:0]        src,
   output logic              idle
);
   logic [7:0] rem;
   logic [1:0] ph;

   // four clk_sys cycles a period, under the half rate limit
   always_ff @(posedge clk_sys) begin
      if (sys_rst || go) begin
         rem <= sys_rst ? 8'h00 : len;
         ph  <= 2'h0;
      end else if (rem != 8'h00) begin
         ph  <= ph + 2'h1;
         rem <= (ph == 2'h3) ? rem - 8'h01 : rem;
      end
   end
   assign src  = (rem != 8'h00 && ph[1]) ? 8'h01 << sel : 8'h00;
   assign idle = (rem == 8'h00);
endmodule

// ### cct_timer16_tb_top.sv
// cct_timer16_tb_top.sv: self-checking bench of the capture/compare timer
// assumes: cct_clk_partner makes the count clocks; checker bound to the timer
`timescale 1ns/1ps

module cct_timer16_tb_top
   import cct_pkg::*;
;
   // -------------
   // signals
   // -------------
   logic        clk_sys = 1'b0;
   logic        sys_rst = 1'b1;
   logic [7:0]  ctrl_reg_a = 8'h00;
   logic [7:0]  action_mask_reg = 8'h00;
   logic [7:0]  mode_reg_a = 8'h00;
   logic [7:0]  mode_reg_b = 8'h00;
   logic [3:0]  irq_mask_reg = 4'h0;
   logic [3:0]  irq_flag_clr = 4'h0;
   logic [15:0] compare_a_reg = 16'h0000;
   logic [15:0] compare_b_reg = 16'h0000;
   logic        sw_capture_req = 1'b0;
   logic        companion_match = 1'b0;
   logic        sensor_meas_start = 1'b0;
   logic [3:0]  cap_in = 4'h0;
   logic        go = 1'b0;
   logic [7:0]  len = 8'h00;
   logic [7:0]  src;
   logic        idle;
   logic [15:0] count_value;
   logic [15:0] capture_value_reg;
   logic [3:0]  irq_flag_reg;
   logic        sw_capture_busy;
   logic        capture_irq;
   logic        match_a_irq;
   logic        match_b_irq;
   logic        overflow_irq;
   logic        modulator_out_pin;
   logic        sensor_running;
   logic        count_clock;
   int          error_cnt = 0;
   int          n_checks = 0;

   // 40 MHz clock
   always #12.5 clk_sys = ~clk_sys;

   cct_timer16 DUT (
      .clk_sys, .sys_rst, .ctrl_reg_a, .action_mask_reg, .mode_reg_a, .mode_reg_b, .irq_mask_reg,
      .compare_a_reg, .compare_b_reg, .sw_capture_req, .irq_flag_clr, .io_clock(src[0]),
      .ext_clock_in_a(src[1]), .ext_clock_in_b(src[2]), .timer0_out_clock(src[3]),
      .timer1_out_clock(src[4] | cap_in[2]), .timer2_out_clock(src[5] | cap_in[3]),
      .sensor_osc_clock(src[6]), .timer_base_clock(src[7]), .ext_capture_pin(cap_in[0]),
      .lf_rx_data_out(cap_in[1]), .companion_match, .sensor_meas_start, .count_value,
      .capture_value_reg, .irq_flag_reg, .sw_capture_busy, .capture_irq, .match_a_irq,
      .match_b_irq, .overflow_irq, .count_clock, .modulator_out_pin, .sensor_running
   );

   cct_clk_partner u_clk (
      .clk_sys, .sys_rst, .go, .sel(cct_clk_sel_t'(mode_reg_a[2:0])), .len, .src, .idle
   );

   // compare, count and report
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   task automatic finish_test;
      if (error_cnt == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // n rising edges on the selected source, then sync latency
   task automatic burst(input logic [7:0] n);
      int t;
      go <= 1'b1;
      len <= n;
      cyc(1);
      go <= 1'b0;
      cyc(1);
      t = 0;
      while (idle !== 1'b1 && t < 2000) begin
         cyc(1);
         t++;
      end
      chk("burst", 16'(idle), 16'h0001);
      cyc(6);
      chk("clk idle", 16'(count_clock), 16'h0000);
   endtask

   task automatic clrf;
      irq_flag_clr <= 4'hf;
      cyc(1);
      irq_flag_clr <= 4'h0;
      cyc(1);
   endtask

   // clear counter while disabled, then set up and enable
   task automatic cfg(input logic [7:0] ca, am, ma, mb);
      ctrl_reg_a <= 8'h04;
      action_mask_reg <= am;
      mode_reg_a <= ma;
      mode_reg_b <= mb;
      cyc(2);
      ctrl_reg_a <= ca;
      clrf();
   endtask

   task automatic t_clksel;
      for (int s = 0; s < 8; s++) begin
         cfg(8'h80, 8'h00, 8'(s), 8'h00);
         burst(8'h05);
         chk("count", count_value, 16'h0005);
      end
      cfg(8'h00, 8'h00, 8'h00, 8'h00);
      burst(8'h03);
      chk("off count", count_value, 16'h0000);
   endtask

   task automatic t_cmp;
      compare_a_reg <= 16'h0002;
      irq_mask_reg <= 4'h2;
      cfg(8'h80, 8'h05, 8'h00, 8'h01);
      burst(8'h03);
      chk("count", count_value, 16'h0000);
      chk("flags", 16'(irq_flag_reg), 16'h0006);
      chk("irq a", 16'(match_a_irq), 16'h0001);
      chk("out", 16'(modulator_out_pin), 16'h0001);
      irq_mask_reg <= 4'h0;
      cyc(1);
      chk("irq a masked", 16'(match_a_irq), 16'h0000);
      clrf();
      chk("cleared", 16'(irq_flag_reg), 16'h0000);
      burst(8'h03);
      chk("out back", 16'(modulator_out_pin), 16'h0000);
   endtask

   task automatic t_noalt;
      compare_a_reg <= 16'h0003;
      compare_b_reg <= 16'h0001;
      cfg(8'h80, 8'h00, 8'h00, 8'h00);
      burst(8'h04);
      chk("count", count_value, 16'h0004);
      chk("both flags", 16'(irq_flag_reg), 16'h0006);
   endtask

   task automatic t_alt;
      compare_a_reg <= 16'h0004;
      compare_b_reg <= 16'h0002;
      cfg(8'h81, 8'h24, 8'h00, 8'h00);
      burst(8'h05);
      chk("alt 1", 16'(irq_flag_reg), 16'h0002);
      chk("alt count", count_value, 16'h0000);
      clrf();
      burst(8'h03);
      chk("alt 2", 16'(irq_flag_reg), 16'h0004);
      clrf();
      burst(8'h05);
      chk("alt 3", 16'(irq_flag_reg), 16'h0002);
   endtask

   task automatic t_single;
      logic [7:0]  mk [3] = '{8'h02, 8'h10, 8'h12};
      logic [15:0] ca [3] = '{16'h0002, 16'h0100, 16'h0002};
      logic [15:0] cb [3] = '{16'h0100, 16'h0002, 16'h0002};
      logic [3:0]  fl [3] = '{4'h2, 4'h4, 4'h6};
      for (int k = 0; k < 3; k++) begin
         compare_a_reg <= ca[k];
         compare_b_reg <= cb[k];
         cfg(8'h80, mk[k], 8'h00, 8'h00);
         burst(8'h06);
         chk("single flag", 16'(irq_flag_reg), 16'(fl[k]));
         chk("single hold", count_value, 16'h0002);
         clrf();
         burst(8'h03);
         chk("single once", 16'(irq_flag_reg), 16'h0000);
      end
   endtask

   // every source and edge code, capture resets counter
   task automatic t_capture;
      for (int s = 0; s < 4; s++) begin
         for (int e = 0; e < 4; e++) begin
            cfg(8'h80, 8'h40, 8'(s * 64 + e * 8), 8'h00);
            burst(8'h05);
            cap_in[s] <= 1'b1;
            cyc(8);
            chk("rise cap", 16'(irq_flag_reg[3]), 16'(e % 2));
            chk("cap reset", count_value, (e % 2) ? 16'h0000 : 16'h0005);
            if (e % 2 == 1)
               chk("cap value", capture_value_reg, 16'h0005);
            clrf();
            cap_in[s] <= 1'b0;
            cyc(8);
            chk("fall cap", 16'(irq_flag_reg[3]), 16'(e / 2));
         end
      end
   endtask

   task automatic t_filter;
      cfg(8'h80, 8'h00, 8'h28, 8'h00);
      burst(8'h05);
      cap_in[0] <= 1'b1;
      burst(8'h02);
      cap_in[0] <= 1'b0;
      burst(8'h04);
      chk("spike", 16'(irq_flag_reg[3]), 16'h0000);
      cap_in[0] <= 1'b1;
      burst(8'h06);
      chk("filtered", 16'(irq_flag_reg[3]), 16'h0001);
      chk("delay", 16'(capture_value_reg > 16'h000c && capture_value_reg < 16'h0011), 16'h0001);
      cap_in[0] <= 1'b0;
   endtask

   task automatic t_swcap;
      int t;
      cfg(8'h80, 8'h00, 8'h00, 8'h00);
      burst(8'h07);
      sw_capture_req <= 1'b1;
      cyc(1);
      sw_capture_req <= 1'b0;
      cyc(1);
      t = 0;
      while (sw_capture_busy !== 1'b0 && t < 50) begin
         cyc(1);
         t++;
      end
      cyc(3);
      chk("sw value", capture_value_reg, 16'h0007);
      chk("sw flag", 16'(irq_flag_reg[3]), 16'h0001);
      chk("sw busy", 16'(sw_capture_busy), 16'h0000);
   endtask

   task automatic t_sensor;
      cfg(8'h80, 8'h00, 8'h20, 8'h03);
      burst(8'h02);
      chk("no start", count_value, 16'h0000);
      sensor_meas_start <= 1'b1;
      burst(8'h06);
      chk("running", 16'(sensor_running), 16'h0001);
      chk("sens count", count_value, 16'h0005);
      companion_match <= 1'b1;
      cyc(1);
      companion_match <= 1'b0;
      cyc(3);
      chk("sens cap", capture_value_reg, 16'h0005);
      sw_capture_req <= 1'b1;
      cyc(1);
      sw_capture_req <= 1'b0;
      cyc(8);
      chk("sw refused", 16'(sw_capture_busy), 16'h0001);
   endtask

   // main sequence
   initial begin
      cyc(16);
      sys_rst <= 1'b0;
      cyc(2);
      chk("reset count", count_value, 16'h0000);
      chk("reset flags", 16'(irq_flag_reg), 16'h0000);
      t_clksel();
      t_cmp();
      t_noalt();
      t_alt();
      t_single();
      t_capture();
      t_filter();
      t_swcap();
      t_sensor();
      finish_test();
   end

   // watchdog
   initial begin
      #1000000;
      error_cnt++;
      finish_test();
   end
endmodule
